// >>> logic/swisd_core.sv
`timescale 1ns/1ps
module swisd_core
  import swisd_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,          // Core clock, 250 MHz
  input  wire logic        resetn,            // Async reset, active low
  // Register bus, one wait state per transfer
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [15:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  // Priority lookup from the ingress parser
  input  wire logic        rx_prio_valid,     // Priority lookup request
  input  wire logic [1:0]  rx_port,           // Ingress port of request
  input  wire logic [2:0]  rx_prio,           // Received VLAN priority
  output logic             regen_valid,       // Remapped priority valid
  output logic      [2:0]  regen_prio,        // Priority for queue choice
  // Events from the lookup engine, all on this clock
  input  wire logic [2:0]  learn_discard,     // Per-port unlearned pulse
  input  wire logic        drop_strobe,       // Drop event pulse
  input  wire logic [1:0]  drop_port,         // Source port of drop
  input  wire logic        drop_untagged,     // Untagged or prio-only
  input  wire logic        drop_vid_ones,     // VLAN id all ones
  input  wire logic        drop_da_found,     // DA in lookup table
  input  wire logic        drop_da_mcast,     // DA is multicast
  input  wire logic        drop_da_bcast,     // DA is broadcast
  input  wire logic        drop_bc_throttle,  // Broadcast over limit
  input  wire logic        drop_src_member,   // Source in VLAN
  input  wire logic        drop_dst_member,   // Destination in VLAN
  input  wire logic        drop_src_fwd,      // Source forwarding
  input  wire logic        drop_dst_fwd,      // Destination forwarding
  input  wire logic        drop_same_port,    // Destination is source
  input  wire logic        drop_da_filter,    // Entry discard flag
  // Request to the system interrupt logic
  output logic             swe_irq            // Interrupt request
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Everything that flops, bar the reset synchroniser, lives here,
  // so one register block covers reset and update alike
  typedef struct packed {
    logic [NPORT-1:0][REMAP_W-1:0] remap;    // Remap tables
    logic [NPORT-1:0][31:0]        cnt;      // Unlearned counters
    logic                          mask;     // Interrupt mask
    logic [CFG_W-1:0]              cfg;      // Drop policy bits
    logic                          pend;     // Drop pending
    logic                          va;       // Record A valid
    logic [1:0]                    pa;       // Record A port
    logic [3:0]                    ca;       // Record A cause
    logic                          vb;       // Record B valid
    logic [1:0]                    pb;       // Record B port
    logic [3:0]                    cb;       // Record B cause
    logic [31:0]                   rdata;    // Read data
    logic                          rdy;      // APB ready
    logic                          err;      // APB error
    logic                          rvld;     // Remap valid
    logic [2:0]                    rprio;    // Remap result
    logic                          irq;      // Interrupt out
  } swisd_state_type;

  localparam swisd_state_type ST_RST = '{
    remap : {NPORT{REMAP_RST}},
    cnt   : '0,
    mask  : MASK_RST,
    default : '0
  };

  swisd_state_type s_q;                      // Registered state
  swisd_state_type s_d;                      // Next state
  logic            rst_meta_q;               // Reset sync stage 1
  logic            rst_sync_q;               // Reset sync stage 2

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Saturating increment, shared by all counters
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
  endfunction

  // Pick one 3-bit field from a remap table
  function automatic logic [2:0] pick(input logic [REMAP_W-1:0] t,
                                     input logic [2:0] p);
    logic [REMAP_W-1:0] sh;
    sh   = t >> (p * 3'h3 + 5'h00);
    pick = sh[PRIO_W-1:0];
  endfunction

  // Cause encoder; first bit says a defined cause was found.
  // Order puts parser checks first, then membership,
  // forwarding, then lookup-dependent filters.
  function automatic logic [4:0] cause(input logic [CFG_W-1:0] c,
                                       input logic [13:0] e);
    logic vid;
    logic untg;
    logic fnd;
    logic mc;
    logic bc;
    logic thr;
    logic sm;
    logic dm;
    logic sf;
    logic df;
    logic same;
    logic filt;
    logic outsider;
    {vid, untg, fnd, mc, bc, thr, sm, dm, sf, df, same, filt} = e[11:0];
    // Outsider: source outside the VLAN while the membership
    // check is on and outsiders are not admitted
    outsider = c[CFG_MEMCHK] & ~c[CFG_ADMITNM] & ~sm;
    // Top bit low means no defined cause: nothing is recorded
    cause = 5'h00;
    if (vid) begin
      cause = {1'b1, C_VID_ONES};
    end else if (c[CFG_TAGONLY] && untg) begin
      cause = {1'b1, C_TAGONLY};
    end else if (outsider) begin
      cause = {1'b1, fnd ? C_SRCNM_FND : C_SRCNM_UNK};
    end else if (!sf) begin
      cause = {1'b1, fnd ? C_SRCFW_FND : C_SRCFW_UNK};
    end else if (fnd) begin
      if (same) begin
        cause = {1'b1, C_SAMEPORT};
      end else if (filt) begin
        cause = {1'b1, C_FILTER};
      end else if (c[CFG_MEMCHK] && !dm) begin
        cause = {1'b1, C_DSTNM_FND};
      end else if (!df) begin
        cause = {1'b1, C_DSTFW_FND};
      end
    end else if (bc) begin
      if (thr) begin
        cause = {1'b1, C_BC_THROT};
      end
    end else if (mc) begin
      if (c[CFG_DROPMC]) begin
        cause = {1'b1, C_UNK_MC};
      end
    end else if (c[CFG_DROPUC]) begin
      cause = {1'b1, C_UNK_UC};
    end
  endfunction

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------

  // Release is synchronous so no flop leaves reset mid-edge
  // Assertion stays asynchronous, so reset works with no clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic [13:0] idx;                          // Word index
  logic        acc;                          // Access phase
  logic        cap;                          // First access cycle
  logic        done;                         // Completing edge
  logic [4:0]  dc;                           // Encoded cause
  logic [31:0] stat;                         // Status word

  assign idx  = paddr[15:2];
  assign acc  = psel & penable;
  assign cap  = acc & ~s_q.rdy;
  assign done = acc & s_q.rdy;
  assign stat = {17'h00000, s_q.cb, s_q.pb, s_q.vb,
                 s_q.ca, s_q.pa, s_q.va, s_q.pend};

  assign dc = cause(s_q.cfg, {2'b00, drop_vid_ones, drop_untagged,
                    drop_da_found, drop_da_mcast, drop_da_bcast,
                    drop_bc_throttle, drop_src_member, drop_dst_member,
                    drop_src_fwd, drop_dst_fwd, drop_same_port,
                    drop_da_filter});

  // One combinational pass builds the whole next state
  always_comb begin
    s_d     = s_q;
    s_d.rdy = cap;                           // One wait state
    s_d.err = 1'b0;

    // Read side effects act on the capture edge, so an event in
    // the wait cycle still lands after the clear.
    if (cap && !pwrite) begin
      s_d.rdata = 32'h00000000;
      case (idx)
        IDX_REMAP0: s_d.rdata = {8'h00, s_q.remap[0]};
        IDX_REMAP1: s_d.rdata = {8'h00, s_q.remap[1]};
        IDX_REMAP2: s_d.rdata = {8'h00, s_q.remap[2]};
        IDX_UNL0: begin
          s_d.rdata  = s_q.cnt[0];
          s_d.cnt[0] = 32'h00000000;
        end
        IDX_UNL1: begin
          s_d.rdata  = s_q.cnt[1];
          s_d.cnt[1] = 32'h00000000;
        end
        IDX_UNL2: begin
          s_d.rdata  = s_q.cnt[2];
          s_d.cnt[2] = 32'h00000000;
        end
        IDX_MASK:   s_d.rdata = {31'h00000000, s_q.mask};
        IDX_STATUS: begin
          s_d.rdata = stat;
          s_d.pend  = 1'b0;
          s_d.va    = 1'b0;
          s_d.pa    = 2'h0;
          s_d.ca    = 4'h0;
          s_d.vb    = 1'b0;
          s_d.pb    = 2'h0;
          s_d.cb    = 4'h0;
        end
        IDX_CFG:    s_d.rdata = {27'h0000000, s_q.cfg};
        default:    s_d.err   = 1'b1;        // Unmapped read
      endcase
    end else if (cap) begin
      // Writes report errors early but take effect on done
      case (idx)
        IDX_REMAP0, IDX_REMAP1, IDX_REMAP2,
        IDX_UNL0, IDX_UNL1, IDX_UNL2,
        IDX_MASK, IDX_STATUS, IDX_CFG: s_d.err = 1'b0;
        default:                       s_d.err = 1'b1;
      endcase
    end
    // The error flag stands only with pready; the completing edge
    // clears it through the default above, so no stray error
    // shows while the bus is idle.

    // Writes; counters and status ignore them
    // Reserved bits of the tables are dropped and read back as 0
    if (done && pwrite) begin
      case (idx)
        IDX_REMAP0: s_d.remap[0] = pwdata[REMAP_W-1:0];
        IDX_REMAP1: s_d.remap[1] = pwdata[REMAP_W-1:0];
        IDX_REMAP2: s_d.remap[2] = pwdata[REMAP_W-1:0];
        IDX_MASK:   s_d.mask     = pwdata[0];
        IDX_CFG:    s_d.cfg      = pwdata[CFG_W-1:0];
        default:    s_d.mask     = s_d.mask;
      endcase
    end

    // Learn discards; an increment after a clear counts from zero
    // Once all ones is reached the guard in sat_inc keeps it there,
    // so software never mistakes a wrap for a quiet port.
    for (int p = 0; p < NPORT; p++) begin
      if (learn_discard[p]) begin
        s_d.cnt[p] = sat_inc(s_d.cnt[p]);
      end
    end

    // Drop recording; set wins over the read clear above.
    // Reserved codes are never produced, so undefined
    // combinations leave the records alone.
    if (drop_strobe && dc[4]) begin
      s_d.pend = 1'b1;
      if (!s_d.va) begin
        s_d.va = 1'b1;
        s_d.pa = drop_port;
        s_d.ca = dc[3:0];
      end else if (!s_d.vb) begin
        s_d.vb = 1'b1;
        s_d.pb = drop_port;
        s_d.cb = dc[3:0];
      end
      // Both full: later drops only keep pending set
      // Limitation: causes of drops after that are lost
    end

    // Priority remap; reserved port gives no result
    // Port code 3 would index past the tables, so it is refused
    // here rather than read out of range.
    s_d.rvld  = rx_prio_valid && (rx_port != PORT_RSVD);
    s_d.rprio = rx_prio;
    if (s_d.rvld) begin
      s_d.rprio = pick(s_q.remap[rx_port], rx_prio);
    end

    // Mask gates only the request, never the status
    s_d.irq = s_d.pend & ~s_d.mask;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Synchronised reset; constants only under reset
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  // Registered outputs keep bus timing free of input paths
  assign prdata      = s_q.rdata;
  assign pready      = s_q.rdy;
  assign pslverr     = s_q.err;
  assign regen_valid = s_q.rvld;
  assign regen_prio  = s_q.rprio;
  assign swe_irq     = s_q.irq;

endmodule

// >>> logic/swisd_pkg.sv
package swisd_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [13:0] IDX_REMAP0  = 14'h1855;  // Port 0 remap table
  localparam logic [13:0] IDX_REMAP1  = 14'h1856;  // Port 1 remap table
  localparam logic [13:0] IDX_REMAP2  = 14'h1857;  // Port 2 remap table
  localparam logic [13:0] IDX_UNL0    = 14'h1858;  // Port 0 unlearned count
  localparam logic [13:0] IDX_UNL1    = 14'h1859;  // Port 1 unlearned count
  localparam logic [13:0] IDX_UNL2    = 14'h185A;  // Port 2 unlearned count
  localparam logic [13:0] IDX_MASK    = 14'h1880;  // Interrupt mask
  localparam logic [13:0] IDX_STATUS  = 14'h1881;  // Drop event status
  localparam logic [13:0] IDX_CFG     = 14'h1882;  // Drop policy config
  localparam int          NPORT       = 3;         // Switch ports

  // ----------------------------------------
  // Field layouts and reset values
  // ----------------------------------------
  localparam int          REMAP_W     = 24;        // Eight 3-bit fields
  localparam int          PRIO_W      = 3;         // Priority width
  localparam logic [23:0] REMAP_RST   = 24'hFAC688; // Identity map 7..0
  localparam logic [31:0] CNT_MAX     = 32'hFFFFFFFF; // Saturation value
  localparam logic [31:0] CNT_ONE     = 32'h00000001; // Counter step
  localparam logic        MASK_RST    = 1'b1;      // Masked after reset
  localparam int          CFG_W       = 5;         // Config bits
  localparam int          CFG_TAGONLY = 0;         // Tagged-only admission
  localparam int          CFG_MEMCHK  = 1;         // Ingress membership check
  localparam int          CFG_ADMITNM = 2;         // Admit outsiders
  localparam int          CFG_DROPUC  = 3;         // Drop unknown unicast
  localparam int          CFG_DROPMC  = 4;         // Drop unknown multicast
  localparam logic [1:0]  PORT_RSVD   = 2'h3;      // Reserved port code

  // ----------------------------------------
  // Drop cause codes
  // ----------------------------------------
  localparam logic [3:0]  C_TAGONLY   = 4'h0;
  localparam logic [3:0]  C_SRCNM_UNK = 4'h1;
  localparam logic [3:0]  C_SRCFW_FND = 4'h2;
  localparam logic [3:0]  C_DSTFW_FND = 4'h3;
  localparam logic [3:0]  C_DSTNM_FND = 4'h4;
  localparam logic [3:0]  C_SRCNM_FND = 4'h5;
  localparam logic [3:0]  C_UNK_UC    = 4'h6;
  localparam logic [3:0]  C_UNK_MC    = 4'h7;
  localparam logic [3:0]  C_BC_THROT  = 4'h8;
  localparam logic [3:0]  C_SRCFW_UNK = 4'h9;
  localparam logic [3:0]  C_SAMEPORT  = 4'hA;
  localparam logic [3:0]  C_FILTER    = 4'hB;
  localparam logic [3:0]  C_VID_ONES  = 4'hE;

endpackage

// >>> testbench/swisd_core_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module swisd_core_checker
  import swisd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_prio_valid,
  input wire logic [1:0]  rx_port,
  input wire logic        regen_valid,
  input wire logic        drop_strobe,
  input wire logic        swe_irq
);
  logic [13:0] idx;  // Word index
  logic        hit;  // Mapped register
  logic        mwr;  // Mask write lands
  assign idx = paddr[15:2];
  assign hit = (idx >= IDX_REMAP0 && idx <= IDX_UNL2) || (idx >= IDX_MASK && idx <= IDX_CFG);
  assign mwr = pready && pwrite && idx == IDX_MASK;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Setup cycle then first access cycle
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready_wait; s_req |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_acc; pready |-> psel && penable; endproperty
  property p_err_map; pready |-> pslverr == !hit; endproperty
  property p_err_quiet; !pready |-> !pslverr; endproperty
  property p_regen_on; rx_prio_valid && rx_port != 2'h3 |=> regen_valid; endproperty
  property p_regen_off; !rx_prio_valid || rx_port == 2'h3 |=> !regen_valid; endproperty
  // Interrupt only rises from a drop or an unmask
  property p_irq_rise; $rose(swe_irq) |-> $past(drop_strobe) || $past(mwr); endproperty
  // Only a bus access can lower it
  property p_irq_hold; swe_irq && !(psel && penable) |=> swe_irq; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  a_ready_acc: assert property (p_ready_acc) else $error("pready idle");
  a_err_map: assert property (p_err_map) else $error("pslverr map");
  a_err_quiet: assert property (p_err_quiet) else $error("pslverr stray");
  a_regen_on: assert property (p_regen_on) else $error("regen missing");
  a_regen_off: assert property (p_regen_off) else $error("regen stray");
  a_irq_rise: assert property (p_irq_rise) else $error("irq no cause");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule

bind swisd_core swisd_core_checker u_swisd_core_checker (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .rx_prio_valid(rx_prio_valid), .rx_port(rx_port), .regen_valid(regen_valid),
  .drop_strobe(drop_strobe), .swe_irq(swe_irq)
);

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb import swisd_pkg::*;;
  // ----------------------------------------
  // Stimulus and model state
  // ----------------------------------------
  logic        core_clk = 1'b0, resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, lv;
  logic        pready, pslverr, err, regen_valid, swe_irq;
  logic        rx_prio_valid = 1'b0, drop_strobe = 1'b0;
  logic [1:0]  rx_port = 2'h0, drop_port = 2'h0;
  logic [2:0]  rx_prio = 3'h0, learn_discard = 3'h0, regen_prio;
  logic [11:0] dq = 12'h0;  // Drop qualifiers, vid_ones at top
  logic [31:0] r24 [3] = '{32'hFAC688, 32'hFAC688, 32'hFAC688};  // Model tables
  int          n_errors = 0, checks_done = 0, seed = 6, pend = 0, mask = 1;
  int          cnt [3] = '{0, 0, 0};  // Model counters
  int          rec [$];               // Model records, cause*4+port
  // One qualifier set per cause; index 13 has none, 14 needs outsiders admitted
  localparam logic [11:0] QUAL [15] = '{12'h43C, 12'h01C, 12'h234, 12'h238, 12'h22C,
    12'h21C, 12'h03C, 12'h13C, 12'h0FC, 12'h034, 12'h23E, 12'h23D, 12'h83C, 12'h23C, 12'h01C};
  localparam logic [3:0] CODE [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF, 4'h6};
  localparam logic [13:0] RIDX [10] = '{IDX_REMAP0, IDX_REMAP1, IDX_REMAP2, IDX_UNL0,
    IDX_UNL1, IDX_UNL2, IDX_MASK, IDX_STATUS, IDX_CFG, 14'h1860};
  localparam logic [31:0] RRST [10] = '{32'hFAC688, 32'hFAC688, 32'hFAC688, 32'h0,
    32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};

  always #2 core_clk = ~core_clk;

  swisd_core u_swisd_core (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_prio_valid(rx_prio_valid),
    .rx_port(rx_port), .rx_prio(rx_prio), .regen_valid(regen_valid),
    .regen_prio(regen_prio), .learn_discard(learn_discard),
    .drop_strobe(drop_strobe), .drop_port(drop_port), .drop_untagged(dq[10]),
    .drop_vid_ones(dq[11]), .drop_da_found(dq[9]), .drop_da_mcast(dq[8]),
    .drop_da_bcast(dq[7]), .drop_bc_throttle(dq[6]), .drop_src_member(dq[5]),
    .drop_dst_member(dq[4]), .drop_src_fwd(dq[3]), .drop_dst_fwd(dq[2]),
    .drop_same_port(dq[1]), .drop_da_filter(dq[0]), .swe_irq(swe_irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One priority lookup, result one cycle later
  task automatic regen(input int p, input int q);
    @(posedge core_clk);
    rx_prio_valid <= 1'b1;
    rx_port <= p[1:0];
    rx_prio <= q[2:0];
    @(posedge core_clk);
    rx_prio_valid <= 1'b0;
    @(posedge core_clk);
    chk("regen_valid", p < 3, regen_valid);
    if (p < 3) chk("regen_prio", r24[p][3*q +: 3], regen_prio);
  endtask

  // Drop pulse; model fills A, then B, then only pending
  task automatic drop(input int e, input logic [1:0] p);
    @(posedge core_clk);
    drop_strobe <= 1'b1;
    drop_port <= p;
    dq <= QUAL[e];
    @(posedge core_clk);
    drop_strobe <= 1'b0;
    if (CODE[e] != 4'hF && rec.size() < 2) rec.push_back(CODE[e] * 4 + p);
    if (CODE[e] != 4'hF) pend = 1;
    #1 chk("irq", pend & ~mask, swe_irq);
  endtask

  task automatic stat();
    int w;
    w = pend;
    foreach (rec[j]) w |= (1 | rec[j] << 1) << (1 + 7 * j);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status", w, rd);
    chk("irq", 32'h0, swe_irq);
    rec.delete();
    pend = 0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (RIDX[k]) begin
      apb(1'b0, RIDX[k], 32'h0);
      chk("reset_value", RRST[k], rd);
      chk("pslverr", k == 9, err);
    end
    apb(1'b1, IDX_UNL0, 32'h1234);
    chk("pslverr", 32'h0, err);
    apb(1'b1, 14'h1860, 32'h5A5A5A5A);
    chk("pslverr", 32'h1, err);
    apb(1'b0, IDX_UNL0, 32'h0);
    chk("count_ro", 32'h0, rd);
    // Identity map first, then random tables per port
    for (int t = 0; t < 2; t++) begin
      for (int p = 0; p < 4; p++) for (int q = 0; q < 8; q++) regen(p, q);
      foreach (r24[p]) begin
        r24[p] = $random(seed) & 32'hFFFFFF;
        apb(1'b1, 14'(IDX_REMAP0 + p), r24[p]);
        apb(1'b0, 14'(IDX_REMAP0 + p), 32'h0);
        chk("remap", r24[p], rd);
      end
    end
    for (int k = 0; k < 200; k++) begin
      @(posedge core_clk);
      lv = $random(seed);
      learn_discard <= lv[2:0];
      foreach (cnt[p]) cnt[p] += lv[p];
    end
    @(posedge core_clk);
    learn_discard <= 3'h0;
    // Second pass proves clear on read
    for (int r = 0; r < 2; r++) foreach (cnt[p]) begin
      apb(1'b0, 14'(IDX_UNL0 + p), 32'h0);
      chk("count", cnt[p], rd);
      cnt[p] = 0;
    end
    apb(1'b1, IDX_CFG, 32'h1B);
    for (int e = 0; e < 14; e++) begin
      drop(e, 2'(e % 3));
      if (e % 2) stat();
    end
    apb(1'b1, IDX_CFG, 32'h1F);
    drop(14, 2'h1);
    stat();
    drop(2, 2'h1);
    drop(3, 2'h2);
    drop(4, 2'h0);
    mask = 0;
    apb(1'b1, IDX_MASK, 32'h0);
    @(posedge core_clk);
    chk("irq", 32'h1, swe_irq);
    mask = 1;
    apb(1'b1, IDX_MASK, 32'h1);
    @(posedge core_clk);
    chk("irq", 32'h0, swe_irq);
    stat();
    mask = 0;
    apb(1'b1, IDX_MASK, 32'h0);
    drop(10, 2'h2);
    stat();
    test_done();
  end
endmodule
